// ===== shared/ssp_pkg.sv
// Package for the synchronous serial shift port: offsets, fields, resets, timing.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
package ssp_pkg;
   // Register offsets. Printed offsets are not all multiples of four, so they are indices.
   localparam logic [7:0] IDX_DATA   = 8'h2B;
   localparam logic [7:0] IDX_CTRL   = 8'h31;
   localparam logic [7:0] IDX_STATUS = 8'h32;
   localparam logic [9:0] ADDR_DATA   = {IDX_DATA, 2'b00};
   localparam logic [9:0] ADDR_CTRL   = {IDX_CTRL, 2'b00};
   localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   // Control field positions
   localparam int CTRL_RUN_BIT   = 7;
   localparam int CTRL_HALT_BIT  = 6;
   localparam int CTRL_KIND_LSB  = 4;
   localparam int CTRL_ORDER_BIT = 3;
   localparam int CTRL_CLK_LSB   = 0;
   // Status field positions
   localparam int STAT_ACTIVE_BIT  = 7;
   localparam int STAT_PART_BIT    = 6;
   localparam int STAT_TXE_BIT     = 5;
   localparam int STAT_RXF_BIT     = 4;
   localparam int STAT_TX_UNDERRUN_FLAG_BIT   = 3;
   localparam int STAT_RX_OVERRUN_FLAG_BIT   = 2;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] RXB_RESET  = 8'h00;
   // Transfer kinds and clock select codes
   localparam logic [1:0] KIND_TX     = 2'h0;
   localparam logic [1:0] KIND_RX     = 2'h1;
   localparam logic [1:0] KIND_DUPLEX = 2'h2;
   localparam logic [2:0] CLK_EXT     = 3'h7;
   localparam logic [2:0] CLK_SLOWEST = 3'h0;
   // Timing: one system-clock edge per internal half period base
   localparam int SYS_CLK_HZ   = 20_000_000;
   localparam int SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
   localparam int BITS_PER_BYTE = 8;
   // Full period exponents of the internal rates (divide by 2^n overall)
   localparam int DIV_EXP_SLOW = 12;
   localparam int DIV_EXP_TB   = 10;
   typedef enum logic [1:0] {SSP_IDLE, SSP_WAIT, SSP_SHIFT, SSP_DONE} ssp_state_t;
endpackage : ssp_pkg

// ===== rtl/ssp_clkgen.sv
// Internal serial clock tick generator and external clock edge detector.
// Assumes CLK_SYS domain; the pin input arrives asynchronous.
`timescale 1ns/1ps
`default_nettype none
module ssp_clkgen
   import ssp_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // Selection
   input  wire logic [2:0] clk_sel,
   input  wire logic       tb_div_sel,
   input  wire logic       run_int,
   // External clock pin
   input  wire logic       sck_in,
   // Edge ticks
   output logic            fall_tick,
   output logic            rise_tick
);
   logic [12:0] div_ff;
   logic        sck_s1_ff;
   logic        sck_s2_ff;
   logic        sck_s3_ff;
   logic        half_tick;
   logic        int_sck_ff;
   logic [3:0]  exp_sel;

   // Divider exponent from the clock select code
   always_comb begin
      case (clk_sel)
         CLK_SLOWEST: exp_sel = tb_div_sel ? 4'(DIV_EXP_TB) : 4'(DIV_EXP_SLOW);
         3'h1:        exp_sel = 4'h8;
         default:     exp_sel = 4'(4'h9 - {1'b0, clk_sel});
      endcase
   end

   // Divider, cleared while stopped, half period of the serial clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_ff <= 13'h0000;
      end else if (ce) begin
         div_ff <= run_int ? 13'(div_ff + 13'h0001) : 13'h0000;
      end
   end
   assign half_tick = run_int && (div_ff[exp_sel - 4'h2 +: 1] == 1'b1) &&
                      ((div_ff & ((13'h0001 << (exp_sel - 4'h2)) - 13'h0001)) == 13'h0000) &&
                      (div_ff != 13'h0000);

   // Synchroniser and internal clock phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_s1_ff  <= 1'b1;
         sck_s2_ff  <= 1'b1;
         sck_s3_ff  <= 1'b1;
         int_sck_ff <= 1'b1;
      end else if (ce) begin
         sck_s1_ff <= sck_in;
         sck_s2_ff <= sck_s1_ff;
         sck_s3_ff <= sck_s2_ff;
         if (!run_int) int_sck_ff <= 1'b1;
         else if (half_tick) int_sck_ff <= ~int_sck_ff;
      end
   end

   // Edge ticks from the chosen source
   always_comb begin
      if (clk_sel == CLK_EXT) begin
         fall_tick = ce && sck_s3_ff && !sck_s2_ff;
         rise_tick = ce && !sck_s3_ff && sck_s2_ff;
      end else begin
         fall_tick = ce && half_tick && int_sck_ff;
         rise_tick = ce && half_tick && !int_sck_ff;
      end
   end
endmodule // ssp_clkgen
`default_nettype wire

// ===== rtl/ssp_core.sv
// Synchronous serial shift port with APB register access.
// Assumes one 20 MHz clock; serial pins come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Run cleared in duplex: finish byte, idle high
// - Force halt clears run, status, buffers
// - Duplex external: underrun flag at shift start
// - Underrun holds data output high
// - Overrun flag; discard data while set
// - Overrun reads with run cleared: old byte, then shifter
// - Clearing overrun also clears buffer full
// - Stop after eight clocks; check active
// - Force halt self clears; zero ignored
// - Kind: transmit, receive, duplex, reserved
// - Bit order: MSB or LSB first
// - Clock select: dividers or external clock
// - Active flag and partial count flag
// - Error flags clear on zero write
// - Run clear keeps error flags
// - Transmit write discarded when not empty
// - Receive and transmit buffers share address
// - Internal duplex waits for buffer service
// - Shift out on fall, sample on rise
module ssp_core
   import ssp_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   input  wire logic        CE,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Rate option
   input  wire logic        TIMEBASE_DIV_SEL,
   // Serial pins and interrupt
   input  wire logic        SERIAL_CLOCK_PIN_IN,
   output logic             SERIAL_CLOCK_PIN_OUT,
   output logic             SERIAL_CLOCK_PIN_OE_N,
   input  wire logic        SERIAL_DATA_IN,
   output logic             SERIAL_DATA_OUT,
   output logic             TRANSFER_INTERRUPT
);
   ssp_state_t  state_ff;
   logic        run_ff, halt_ff, order_ff;
   logic [1:0]  kind_ff;
   logic [2:0]  csel_ff;
   logic        active_ff, part_ff, txe_ff, rxf_ff, tx_underrun_flag_ff, rx_overrun_flag_ff;
   logic [7:0]  rxb_ff, txb_ff, shift_ff;
   logic [3:0]  cnt_ff;
   logic        si_s1_ff, si_s2_ff;
   logic        rd_second_ff;
   logic        fall_tick, rise_tick;
   logic        ext_clk, ext_clk_ff, run_int;
   logic        acc_wr, acc_rd;
   logic [9:0]  addr_w;
   logic        wr_ctrl, wr_stat, wr_data, rd_data;
   logic        rx_used, tx_used, serviced;
   logic [7:0]  status_w, ctrl_w;
   logic        sck_out_ff;

   // Pick the next outgoing bit for the chosen order
   function automatic logic out_bit(input logic [7:0] d, input logic lsb);
      return lsb ? d[0] : d[7];
   endfunction

   // Shift one bit in at the far end for the chosen order
   function automatic logic [7:0] shift_in(input logic [7:0] d, input logic lsb, input logic b);
      return lsb ? {b, d[7:1]} : {d[6:0], b};
   endfunction

   assign ext_clk = (csel_ff == CLK_EXT);
   assign rx_used = (kind_ff != KIND_TX);
   assign tx_used = (kind_ff != KIND_RX);
   // Internal clock runs only while shifting
   assign run_int = !ext_clk && (state_ff == SSP_SHIFT);

   ssp_clkgen u_clkgen (
      .clk        (CLK_SYS),
      .rst_n      (RST_N),
      .ce         (CE),
      .clk_sel    (csel_ff),
      .tb_div_sel (TIMEBASE_DIV_SEL),
      .run_int    (run_int),
      .sck_in     (SERIAL_CLOCK_PIN_IN),
      .fall_tick  (fall_tick),
      .rise_tick  (rise_tick)
   );

   // APB decode, zero wait state
   assign addr_w  = PADDR[9:0];
   assign acc_wr  = PSEL && PENABLE && PWRITE && CE;
   assign acc_rd  = PSEL && PENABLE && !PWRITE && CE;
   assign wr_ctrl = acc_wr && (addr_w == ADDR_CTRL) && (PADDR[11:10] == 2'b00);
   assign wr_stat = acc_wr && (addr_w == ADDR_STATUS) && (PADDR[11:10] == 2'b00);
   assign wr_data = acc_wr && (addr_w == ADDR_DATA) && (PADDR[11:10] == 2'b00);
   assign rd_data = acc_rd && (addr_w == ADDR_DATA) && (PADDR[11:10] == 2'b00);

   assign status_w = {active_ff, part_ff, txe_ff, rxf_ff, tx_underrun_flag_ff, rx_overrun_flag_ff, 2'b00};
   assign ctrl_w   = {run_ff, halt_ff, kind_ff, order_ff, csel_ff};
   // Internal duplex may continue only when both buffers were serviced
   assign serviced = (!rx_used || !rxf_ff) && (!tx_used || !txe_ff);

   // APB answer registers
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA  <= 32'h00000000;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !(PADDR[11:10] == 2'b00 &&
                    (addr_w == ADDR_DATA || addr_w == ADDR_CTRL || addr_w == ADDR_STATUS));
         if (PSEL && !PENABLE && !PWRITE) begin
            case (addr_w)
               ADDR_DATA:   PRDATA <= {24'h000000, (rd_second_ff ? shift_ff : rxb_ff)};
               ADDR_CTRL:   PRDATA <= {24'h000000, ctrl_w};
               ADDR_STATUS: PRDATA <= {24'h000000, status_w};
               default:     PRDATA <= 32'h00000000;
            endcase
         end
      end
   end
   // The access phase uses the one-cycle PREADY; ack asserted in access cycle
   // Control register and self-clearing halt
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         {run_ff, halt_ff, kind_ff, order_ff, csel_ff} <= CTRL_RESET;
      end else if (CE) begin
         if (halt_ff) begin
            halt_ff <= 1'b0;
            run_ff  <= 1'b0;
         end else if (wr_ctrl && PREADY) begin
            run_ff   <= PWDATA[CTRL_RUN_BIT];
            halt_ff  <= PWDATA[CTRL_HALT_BIT];
            kind_ff  <= PWDATA[CTRL_KIND_LSB +: 2];
            order_ff <= PWDATA[CTRL_ORDER_BIT];
            csel_ff  <= PWDATA[CTRL_CLK_LSB +: 3];
         end
      end
   end

   // Data input synchroniser
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         si_s1_ff <= 1'b1;
         si_s2_ff <= 1'b1;
      end else if (CE) begin
         si_s1_ff <= SERIAL_DATA_IN;
         si_s2_ff <= si_s1_ff;
      end
   end

   // Transfer engine, buffers and status flags
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_ff     <= SSP_IDLE;
         active_ff    <= 1'b0;
         part_ff      <= 1'b0;
         txe_ff       <= 1'b1;
         rxf_ff       <= 1'b0;
         tx_underrun_flag_ff     <= 1'b0;
         rx_overrun_flag_ff     <= 1'b0;
         rxb_ff       <= RXB_RESET;
         txb_ff       <= 8'h00;
         shift_ff     <= 8'h00;
         cnt_ff       <= 4'h0;
         sck_out_ff   <= 1'b1;
         SERIAL_DATA_OUT <= 1'b1;
         TRANSFER_INTERRUPT <= 1'b0;
         rd_second_ff <= 1'b0;
         ext_clk_ff   <= 1'b0;
      end else if (CE) begin
         TRANSFER_INTERRUPT <= 1'b0;
         ext_clk_ff <= ext_clk;
         if (halt_ff) begin
            state_ff  <= SSP_IDLE;
            active_ff <= 1'b0;
            part_ff   <= 1'b0;
            txe_ff    <= 1'b1;
            rxf_ff    <= 1'b0;
            tx_underrun_flag_ff  <= 1'b0;
            rx_overrun_flag_ff  <= 1'b0;
            rxb_ff    <= RXB_RESET;
            txb_ff    <= 8'h00;
            cnt_ff    <= 4'h0;
            sck_out_ff <= 1'b1;
            SERIAL_DATA_OUT <= 1'b1;
            rd_second_ff <= 1'b0;
         end else begin
            // Buffer accesses from software
            if (wr_data && PREADY && txe_ff) begin
               txb_ff <= PWDATA[7:0];
               txe_ff <= 1'b0;
            end
            if (rd_data && PREADY) begin
               rxf_ff <= 1'b0;
               if (rx_overrun_flag_ff && !run_ff) rd_second_ff <= 1'b1;
            end
            // Zero clears error flags; one ignored
            if (wr_stat && PREADY && !PWDATA[STAT_TX_UNDERRUN_FLAG_BIT]) tx_underrun_flag_ff <= 1'b0;
            if (wr_stat && PREADY && !PWDATA[STAT_RX_OVERRUN_FLAG_BIT]) begin
               rx_overrun_flag_ff     <= 1'b0;
               rxf_ff       <= 1'b0;
               rd_second_ff <= 1'b0;
            end
            case (state_ff)
               SSP_IDLE: begin
                  SERIAL_DATA_OUT <= 1'b1;
                  sck_out_ff <= 1'b1;
                  if (run_ff && (ext_clk || !tx_used || !txe_ff)) begin
                     state_ff <= ext_clk ? SSP_WAIT : SSP_SHIFT;
                     cnt_ff   <= 4'h0;
                  end
               end
               SSP_WAIT, SSP_SHIFT: begin
                  if (fall_tick && cnt_ff < 4'(BITS_PER_BYTE)) begin
                     if (cnt_ff == 4'h0) begin
                        if (!run_ff) begin
                           state_ff  <= SSP_IDLE;
                           active_ff <= 1'b0;
                        end else begin
                           active_ff <= 1'b1;
                           part_ff   <= 1'b1;
                           cnt_ff    <= 4'h1;
                           state_ff  <= SSP_SHIFT;
                           if (tx_used && txe_ff && ext_clk && kind_ff == KIND_DUPLEX) begin
                              tx_underrun_flag_ff <= 1'b1;
                              SERIAL_DATA_OUT <= 1'b1;
                           end else if (tx_used && !tx_underrun_flag_ff) begin
                              shift_ff <= txb_ff;
                              txe_ff   <= 1'b1;
                              SERIAL_DATA_OUT <= out_bit(txb_ff, order_ff);
                           end
                        end
                     end else begin
                        cnt_ff <= 4'(cnt_ff + 4'h1);
                        if (tx_underrun_flag_ff || !tx_used) SERIAL_DATA_OUT <= 1'b1;
                        else SERIAL_DATA_OUT <= out_bit(shift_ff, order_ff);
                     end
                     if (!ext_clk) sck_out_ff <= 1'b0;
                  end
                  if (rise_tick && cnt_ff != 4'h0) begin
                     if (!ext_clk) sck_out_ff <= 1'b1;
                     if (!rx_overrun_flag_ff) shift_ff <= shift_in(shift_ff, order_ff, si_s2_ff);
                     if (cnt_ff == 4'(BITS_PER_BYTE)) begin
                        part_ff  <= 1'b0;
                        cnt_ff   <= 4'h0;
                        TRANSFER_INTERRUPT <= 1'b1;
                        if (rx_used) begin
                           if (rxf_ff && ext_clk && !rx_overrun_flag_ff) rx_overrun_flag_ff <= 1'b1;
                           else if (!rx_overrun_flag_ff) begin
                              rxb_ff <= shift_in(shift_ff, order_ff, si_s2_ff);
                              rxf_ff <= 1'b1;
                           end
                        end
                        if (!ext_clk) begin
                           state_ff <= SSP_DONE;
                        end else if (!run_ff) begin
                           state_ff  <= SSP_IDLE;
                           active_ff <= 1'b0;
                        end
                     end
                  end
               end
               SSP_DONE: begin
                  sck_out_ff <= 1'b1;
                  if (!run_ff) begin
                     state_ff  <= SSP_IDLE;
                     active_ff <= 1'b0;
                     SERIAL_DATA_OUT <= 1'b1;
                  end else if (serviced) begin
                     state_ff <= SSP_SHIFT;
                  end
               end
               default: state_ff <= SSP_IDLE;
            endcase
         end
      end
   end

   // Serial clock pin drive: output enabled low only for internal clock
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         SERIAL_CLOCK_PIN_OUT  <= 1'b1;
         SERIAL_CLOCK_PIN_OE_N <= 1'b1;
      end else if (CE) begin
         SERIAL_CLOCK_PIN_OUT  <= sck_out_ff;
         SERIAL_CLOCK_PIN_OE_N <= ext_clk_ff;
      end
   end

   // Checks
   a_halt_clears_run: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (CE && halt_ff) |=> !run_ff && !halt_ff) else $error("halt did not clear run");
   a_halt_clears_stat: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (CE && halt_ff) |=> !tx_underrun_flag_ff && !rx_overrun_flag_ff && txe_ff && !rxf_ff) else $error("halt left status");
   a_underrun_out_high: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      tx_underrun_flag_ff && $past(tx_underrun_flag_ff) && !halt_ff |-> SERIAL_DATA_OUT) else $error("data out low in underrun");
   a_underrun_sets: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (fall_tick && !halt_ff && run_ff && cnt_ff == 4'h0 && state_ff != SSP_IDLE && state_ff != SSP_DONE &&
       ext_clk && kind_ff == KIND_DUPLEX && txe_ff) |=> tx_underrun_flag_ff) else $error("underrun flag not set");
   a_overrun_keeps_rxb: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      rx_overrun_flag_ff && $past(rx_overrun_flag_ff) && !$past(halt_ff) |-> $stable(rxb_ff)) else $error("buffer changed in overrun");
   a_txwrite_refused: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (wr_data && PREADY && !txe_ff && !halt_ff) |=> $stable(txb_ff)) else $error("full tx buffer written");
   // A byte ending in the same cycle may set the flags again; the set wins
   a_rx_overrun_flag_clr_rxf: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (wr_stat && PREADY && !PWDATA[STAT_RX_OVERRUN_FLAG_BIT] && !(rise_tick && cnt_ff == 4'h8))
      |=> !rxf_ff && !rx_overrun_flag_ff) else $error("rxf not cleared");
   a_run_keeps_err: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (CE && tx_underrun_flag_ff && !halt_ff && !(wr_stat && PREADY)) |=> tx_underrun_flag_ff) else $error("tx error lost");
   a_part_count: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      part_ff |-> (cnt_ff >= 4'h1 && cnt_ff <= 4'h8)) else $error("partial flag count wrong");
   a_part_active: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      part_ff |-> active_ff) else $error("partial flag without active");
   a_idle_out_high: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (state_ff == SSP_IDLE) ##1 (state_ff == SSP_IDLE) |-> SERIAL_DATA_OUT) else $error("idle line low");
   a_idle_sck_high: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (state_ff == SSP_IDLE) ##1 (state_ff == SSP_IDLE) |-> sck_out_ff) else $error("idle clock low");
   a_irq_byte_end: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      TRANSFER_INTERRUPT |-> !part_ff && cnt_ff == 4'h0) else $error("interrupt before byte end");
   a_irq_one_cycle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      TRANSFER_INTERRUPT |=> !TRANSFER_INTERRUPT) else $error("interrupt pulse too long");
   // Cover points for the main scenarios
   c_byte_done: cover property (@(posedge CLK_SYS) disable iff (!RST_N) $fell(part_ff));
   c_underrun: cover property (@(posedge CLK_SYS) disable iff (!RST_N) $rose(tx_underrun_flag_ff));
   c_overrun: cover property (@(posedge CLK_SYS) disable iff (!RST_N) $rose(rx_overrun_flag_ff));
   c_autowait: cover property (@(posedge CLK_SYS) disable iff (!RST_N) state_ff == SSP_DONE ##1 state_ff == SSP_SHIFT);
endmodule // ssp_core
`default_nettype wire

// ===== verif/ssp_peer_model.sv
// Serial peer for the shift port: drives the external clock and data, captures device output.
// Assumes the device is set to external clock; half periods are six system cycles.
`timescale 1ns/1ps
`default_nettype none
module ssp_peer_model (
   // System clock for pacing
   input  wire logic clk,
   // Serial lines
   output logic      sck,
   output logic      sdo,
   input  wire logic sdi
);
   // Clock idles high, data starts high
   initial begin
      sck = 1'b1;
      sdo = 1'b1;
   end
   // One frame of nbits, wire order first bit in bit 7
   task automatic frame(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < nbits; i++) begin
         repeat (6) @(posedge clk);
         sck <= 1'b0;
         sdo <= tx[7 - i];
         repeat (6) @(posedge clk);
         sck <= 1'b1;
         rx[7 - i] = sdi;
      end
      // Released line must not keep a valid-looking level
      repeat (6) @(posedge clk);
      sdo <= ~sdo;
   endtask
endmodule // ssp_peer_model
`default_nettype wire

// ===== verif/sync_serial_shift_port_bench.sv
// Self-checking bench for the shift port: APB register tasks and an external serial peer.
// Assumes ssp_pkg offsets and the designer's status bit layout.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_shift_port_bench;
   import ssp_pkg::*;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic        sck_out, oe_n, sdo_dev, irq, tb_sel;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  v, prx;
   wire         peer_sck, peer_sdo;
   wire         sck_wire = oe_n ? peer_sck : sck_out;
   int          miscompares, n_tests, cyc, irq_cnt, n;
   ssp_core uut (.CLK_SYS(clk), .RST_N(rst_n), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .TIMEBASE_DIV_SEL(tb_sel), .SERIAL_CLOCK_PIN_IN(sck_wire),
      .SERIAL_CLOCK_PIN_OUT(sck_out), .SERIAL_CLOCK_PIN_OE_N(oe_n), .SERIAL_DATA_IN(peer_sdo),
      .SERIAL_DATA_OUT(sdo_dev), .TRANSFER_INTERRUPT(irq));
   ssp_peer_model peer (.clk(clk), .sck(peer_sck), .sdo(peer_sdo), .sdi(sdo_dev));
   // Clock, cycle limit, interrupt pulse count
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (irq === 1'b1) irq_cnt++;
      if (cyc == 30000) begin
         miscompares++;
         test_done();
      end
   end
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, a};
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      // Only the bench cycle limit ends this wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 8'h00, q, e);
      d = q[7:0];
   endtask
   // Main sequence
   initial begin
      logic [31:0] q;
      logic e;
      {rst_n, psel, penable, pwrite, paddr, pwdata, tb_sel} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(ADDR_CTRL, v); chk("ctrl reset", v, 8'h00);
      rd(ADDR_STATUS, v); chk("status reset", v & 8'hFC, 8'h20);
      apb(1'b0, 10'h3FC, 8'h00, q, e); chk("unmapped err", {7'h00, e}, 8'h01);
      // Duplex, external clock, MSB first
      wr(ADDR_DATA, 8'hA5);
      rd(ADDR_STATUS, v); chk("tx not empty", v & 8'hFC, 8'h00);
      wr(ADDR_CTRL, 8'hA7);
      peer.frame(8'h3C, 8, prx); repeat (8) @(posedge clk);
      chk("wire byte 1", prx, 8'hA5);
      chk("irq after byte 1", 8'(irq_cnt), 8'h01);
      rd(ADDR_STATUS, v); chk("status byte 1", v & 8'hFC, 8'hB0);
      rd(ADDR_DATA, v); chk("rx byte 1", v, 8'h3C);
      peer.frame(8'h96, 8, prx); repeat (8) @(posedge clk);
      chk("underrun line high", prx, 8'hFF);
      chk("irq after byte 2", 8'(irq_cnt), 8'h02);
      rd(ADDR_STATUS, v); chk("underrun status", v & 8'hFC, 8'hB8);
      peer.frame(8'h11, 8, prx); repeat (8) @(posedge clk);
      rd(ADDR_STATUS, v); chk("overrun status", v & 8'h1C, 8'h1C);
      wr(ADDR_STATUS, 8'hFF);
      rd(ADDR_STATUS, v); chk("flags kept on ones", v & 8'h0C, 8'h0C);
      wr(ADDR_CTRL, 8'h27);
      rd(ADDR_STATUS, v); chk("flags kept on stop", v & 8'h0C, 8'h0C);
      rd(ADDR_DATA, v); chk("rx before error", v, 8'h96);
      rd(ADDR_DATA, v); chk("shifter at error", v, 8'h11);
      peer.frame(8'h5A, 8, prx); repeat (8) @(posedge clk);
      rd(ADDR_STATUS, v); chk("active after stop", v & 8'h80, 8'h00);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, v); chk("flags cleared", v & 8'h1C, 8'h00);
      // Forced halt in mid byte
      wr(ADDR_DATA, 8'h5A);
      wr(ADDR_CTRL, 8'hA7);
      peer.frame(8'hFF, 3, prx);
      rd(ADDR_STATUS, v); chk("partial count", v & 8'hC0, 8'hC0);
      wr(ADDR_CTRL, 8'h67);
      rd(ADDR_CTRL, v); chk("halt self clear", v, 8'h27);
      rd(ADDR_STATUS, v); chk("halt status", v & 8'hFC, 8'h20);
      rd(ADDR_DATA, v); chk("halt rx buffer", v, 8'h00);
      // LSB first, second tx write discarded
      wr(ADDR_DATA, 8'hC1);
      wr(ADDR_DATA, 8'h0F);
      wr(ADDR_CTRL, 8'hAF);
      peer.frame(8'h35, 8, prx); repeat (8) @(posedge clk);
      chk("lsb wire byte", prx, 8'h83);
      rd(ADDR_DATA, v); chk("lsb rx byte", v, 8'hAC);
      wr(ADDR_CTRL, 8'h6F);
      // Receive only, external clock: output line stays high
      wr(ADDR_CTRL, 8'h97);
      peer.frame(8'h3C, 8, prx); repeat (8) @(posedge clk);
      chk("rx only line", prx, 8'hFF);
      rd(ADDR_DATA, v); chk("rx only byte", v, 8'h3C);
      wr(ADDR_CTRL, 8'h57);
      // Internal clock, transmit only, then automatic wait
      wr(ADDR_CTRL, 8'h06);
      wr(ADDR_DATA, 8'h5A);
      n = irq_cnt;
      wr(ADDR_CTRL, 8'h86);
      for (int k = 0; k < 5000 && irq_cnt == n; k++) @(posedge clk);
      chk("internal drive", {7'h00, oe_n}, 8'h00);
      chk("internal byte irq", 8'(irq_cnt - n), 8'h01);
      repeat (200) @(posedge clk);
      chk("wait clock high", {7'h00, sck_out}, 8'h01);
      wr(ADDR_DATA, 8'hC3);
      for (int k = 0; k < 5000 && irq_cnt == n + 1; k++) @(posedge clk);
      chk("resume after wait", 8'(irq_cnt - n), 8'h02);
      wr(ADDR_CTRL, 8'h46);
      // Slowest code with the timebase option: byte well under the plain rate
      tb_sel <= 1'b1;
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_DATA, 8'h5A);
      n = irq_cnt;
      wr(ADDR_CTRL, 8'h80);
      for (int k = 0; k < 10000 && irq_cnt == n; k++) @(posedge clk);
      chk("timebase rate byte", 8'(irq_cnt - n), 8'h01);
      wr(ADDR_CTRL, 8'h40);
      test_done();
   end
endmodule // sync_serial_shift_port_bench
`default_nettype wire
